/* tb/analog_side_model.sv */
`timescale 1ns/1ns
module analog_side_model (
  input wire logic       clk, high_side_en, ov_req, oc_req,
  input wire logic [7:0] temp_c, temp_limit, temp_restart,
  output logic           ov_cmp, oc_cmp, hot_cmp, cool_cmp, win_low_cmp, win_high_cmp
);
  logic [7:0] vout_r = 8'h00;
  // The output only climbs while the high side switches, so the low window comparator follows the drivers.
  always_ff @(posedge clk)
    vout_r <= !high_side_en ? 8'h00 : (vout_r < 8'h64 ? vout_r + 8'h01 : vout_r);
  assign win_low_cmp  = vout_r < 8'h5A;
  assign win_high_cmp = ov_req;
  assign ov_cmp       = ov_req;
  assign oc_cmp       = oc_req;
  assign hot_cmp      = temp_c > temp_limit;
  assign cool_cmp     = temp_c < temp_restart;
endmodule : analog_side_model

/* tb/power_fault_props.sv */
`timescale 1ns/1ns
module power_fault_props (
  input wire logic        clk, rst_b, psel, penable, pready, pslverr, ov_cmp, win_low_cmp,
  input wire logic        high_side_en, low_side_en, prebias_sample, ramp_from_prebias,
  input wire logic        output_in_range_flag, fault_latched,
  input wire logic [7:0]  temp_limit, temp_restart,
  input wire logic [10:0] input_low_lockout
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  apb_err_a: assert property (pslverr |-> psel && penable) else $error("stray slave error");
  lock_range_a: assert property (input_low_lockout >= 11'h17B && input_low_lockout <= 11'h528)
    else $error("lockout out of range");
  restart_hyst_a: assert property (temp_restart == temp_limit - 8'h0F)
    else $error("restart threshold wrong");
  ov_flag_a: assert property (ov_cmp[*4] |-> !output_in_range_flag)
    else $error("flag during overvoltage");
  win_flag_a: assert property (win_low_cmp[*4] |-> !output_in_range_flag)
    else $error("flag outside window");
  ov_stop_a: assert property (ov_cmp[*6] |-> !high_side_en)
    else $error("high side on in overvoltage");
  latch_off_a: assert property (fault_latched |-> !high_side_en && !low_side_en)
    else $error("drivers on while latched");
  sample_pulse_a: assert property (prebias_sample |=> !prebias_sample)
    else $error("sample pulse too long");
  prebias_drv_a: assert property (ramp_from_prebias |-> high_side_en && low_side_en)
    else $error("drivers off in pre-bias ramp");
endmodule : power_fault_props

/* tb/test_power_fault_supervisor.sv */
`timescale 1ns/1ns
module test_power_fault_supervisor;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic ov_req = 1'b0, oc_req = 1'b0, strap_low_pin = 1'b0, in_low_cmp = 1'b0;
  logic pready, pslverr, high_side_en, output_in_range_flag;
  logic ov_cmp, oc_cmp, hot_cmp, cool_cmp, win_low_cmp, win_high_cmp;
  logic [7:0]  paddr = 8'h00, temp_c = 8'h19, temp_limit, temp_restart;
  logic [10:0] input_low_lockout;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  int fail_count = 0, check_count = 0;
  always #5 clk = ~clk;
  power_fault_supervisor i_dut (.*, .pb_above_tgt_cmp(1'b0), .pb_above_ov_cmp(1'b0),
    .ext_clk_sel(1'b0), .strap_high_pin(1'b0), .win_high_pct(),
    .win_low_pct(), .ov_pct(), .low_side_en(), .prebias_sample(), .ramp_from_prebias(),
    .duty_hold_prebias(), .ramp_down(), .fault_latched());
  analog_side_model i_model (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wait_flag(input logic v);
    int n;
    n = 0;
    while (output_in_range_flag !== v && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, output_in_range_flag}, {31'h0, v});
  endtask : wait_flag
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : do_reset
  task automatic t_regs;
    apb(1'b0, power_fault_pkg::OFS_THR, 32'h0);    chk(rd, power_fault_pkg::THR_RST);
    apb(1'b0, power_fault_pkg::OFS_RESP, 32'h0);   chk(rd, power_fault_pkg::RESP_RST);
    apb(1'b0, power_fault_pkg::OFS_WINDOW, 32'h0); chk(rd, power_fault_pkg::WINDOW_RST);
    apb(1'b0, power_fault_pkg::OFS_TEMP, 32'h0);   chk(rd, power_fault_pkg::TEMP_RST);
    apb(1'b0, 8'h40, 32'h0);                       chk({rd[30:0], err}, 32'h1);
    chk({21'h0, input_low_lockout}, {21'h0, power_fault_pkg::THR_STRAP_OPEN});
    $display("register test done");
  endtask : t_regs
  task automatic t_lockout;
    strap_low_pin <= 1'b1;
    do_reset();
    chk({21'h0, input_low_lockout}, {21'h0, power_fault_pkg::THR_STRAP_LOW});
    apb(1'b1, power_fault_pkg::OFS_CTRL, 32'h0000_0004);
    apb(1'b1, power_fault_pkg::OFS_THR, 32'h0000_0010);
    repeat (3) @(posedge clk);
    chk({21'h0, input_low_lockout}, {21'h0, power_fault_pkg::THR_MIN});
    apb(1'b1, power_fault_pkg::OFS_THR, 32'h0000_0190);
    repeat (3) @(posedge clk);
    chk({21'h0, input_low_lockout}, 32'h0000_0190);
    $display("lockout test done");
  endtask : t_lockout
  task automatic t_faults;
    apb(1'b1, power_fault_pkg::OFS_SEQ, 32'h0002_0001);
    apb(1'b1, power_fault_pkg::OFS_PGCFG, 32'h0001_0001);
    apb(1'b1, power_fault_pkg::OFS_CTRL, 32'h0000_0001);
    wait_flag(1'b1);
    ov_req <= 1'b1;
    wait_flag(1'b0);
    repeat (10) @(posedge clk);
    chk({31'h0, high_side_en}, 32'h0);
    ov_req <= 1'b0;
    wait_flag(1'b1);
    temp_c <= 8'h82;
    wait_flag(1'b0);
    temp_c <= 8'h78;
    repeat (60) @(posedge clk);
    chk({31'h0, high_side_en}, 32'h0);
    temp_c <= 8'h50;
    wait_flag(1'b1);
    oc_req <= 1'b1;
    wait_flag(1'b0);
    repeat (10) @(posedge clk);
    chk({31'h0, high_side_en}, 32'h0);
    oc_req <= 1'b0;
    wait_flag(1'b1);
    $display("fault test done");
  endtask : t_faults
  task automatic t_latch;
    apb(1'b1, power_fault_pkg::OFS_RESP, 32'h0000_1222);
    apb(1'b1, power_fault_pkg::OFS_FDLY, 32'h0001_0003);
    in_low_cmp <= 1'b1;
    repeat (20) @(posedge clk);
    chk({31'h0, high_side_en}, 32'h1);
    repeat (400) @(posedge clk);
    in_low_cmp <= 1'b0;
    repeat (20) @(posedge clk);
    chk({31'h0, high_side_en}, 32'h0);
    apb(1'b1, power_fault_pkg::OFS_CTRL, 32'h0000_0003);
    wait_flag(1'b1);
    $display("latch test done");
  endtask : t_latch
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial
  begin
    do_reset();
    t_regs();
    t_lockout();
    t_faults();
    t_latch();
    summarize();
  end
  initial
  begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule : test_power_fault_supervisor
bind power_fault_supervisor power_fault_props i_props (.*);

/* verilog/power_fault_pkg.sv */
package power_fault_pkg;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned TICK_CYC      = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STRAP_SETTLE  = 3;

  // --------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_THR    = 8'h04;
  localparam logic [7:0] OFS_RESP   = 8'h08;
  localparam logic [7:0] OFS_SEQ    = 8'h0C;
  localparam logic [7:0] OFS_PGCFG  = 8'h10;
  localparam logic [7:0] OFS_WINDOW = 8'h14;
  localparam logic [7:0] OFS_TEMP   = 8'h18;
  localparam logic [7:0] OFS_FDLY   = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int unsigned CTRL_ENABLE_BIT   = 0;
  localparam int unsigned CTRL_RESTART_BIT  = 1;
  localparam int unsigned CTRL_THR_OVR_BIT  = 2;
  localparam int unsigned RESP_MODE_W       = 4;
  localparam int unsigned RESP_RETRY_LSB    = 16;
  localparam int unsigned PG_INDEP_BIT      = 16;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] THR_RST    = 32'h0000_028A;
  localparam logic [31:0] RESP_RST   = 32'h0000_2222;
  localparam logic [31:0] SEQ_RST    = 32'h03E8_03E8;
  localparam logic [31:0] PGCFG_RST  = 32'h0000_03E8;
  localparam logic [31:0] WINDOW_RST = 32'h000F_0A0F;
  localparam logic [31:0] TEMP_RST   = 32'h0000_007D;
  localparam logic [31:0] FDLY_RST   = 32'h03E8_03E8;

  // --------------------------------------------------------------------------
  // Lockout thresholds in 10 mV units, thermal hysteresis in degrees
  // --------------------------------------------------------------------------
  localparam logic [10:0] THR_STRAP_LOW  = 11'h1C2;
  localparam logic [10:0] THR_STRAP_OPEN = 11'h28A;
  localparam logic [10:0] THR_STRAP_HIGH = 11'h3FC;
  localparam logic [10:0] THR_MIN        = 11'h17B;
  localparam logic [10:0] THR_MAX        = 11'h528;
  localparam logic [7:0]  TEMP_HYST      = 8'h0F;

  // --------------------------------------------------------------------------
  // Fault sources and response modes
  // --------------------------------------------------------------------------
  localparam int unsigned NSRC    = 4;
  localparam int unsigned SRC_OV  = 0;
  localparam int unsigned SRC_OC  = 1;
  localparam int unsigned SRC_TMP = 2;
  localparam int unsigned SRC_UVL = 3;

  localparam logic [2:0] RESP_CONT      = 3'h0;
  localparam logic [2:0] RESP_DLY_SHUT  = 3'h1;
  localparam logic [2:0] RESP_IMM       = 3'h2;
  localparam logic [2:0] RESP_RETRY_INF = 3'h3;
  localparam logic [2:0] RESP_RETRY_N   = 3'h4;
  localparam logic [2:0] RESP_LOWSIDE   = 3'h5;

  typedef enum logic [2:0] {
    ST_OFF, ST_DELAY, ST_RAMP, ST_RUN, ST_WAIT_CLEAR, ST_RETRY_WAIT, ST_LOWSIDE, ST_LATCHED
  } seq_state_t;

endpackage : power_fault_pkg

/* verilog/power_fault_supervisor.sv */
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ns

// Overview of operation
// RL1: Lockout threshold from three-level strap: low 4.5 V, open 6.5 V, high 10.2 V.
// RL2: Host may program lockout threshold anywhere from 3.79 V to 13.2 V.
// RL3: Input low fault: continue, delayed shutdown, or immediate shutdown with retry count.
// RL4: After delayed shutdown on input low, stay off until an explicit restart.
// RL5: Range flag only while output inside +15%/-10% window and no fault.
// RL6: Range flag waits a delay after conditions met, default equals ramp time.
// RL7: Host may set the range flag delay independently of the ramp time.
// RL8: Overvoltage drops the range flag and starts the selected response; default 15%.
// RL9: Overvoltage responses: immediate shutdown with retries, or low side held on.
// RL10: Default overvoltage response shuts down and re-enables once the fault clears.
// RL11: With an external switching clock only immediate overvoltage shutdown is allowed.
// RL12: Sample the output for pre-bias before starting the ramp.
// RL13: Pre-bias below target: ramp from pre-bias, finish within ramp time after delay.
// RL14: Pre-bias above target: match duty, flag after ramp period, then ramp down.
// RL15: Pre-bias above overvoltage limit: no turn-on, overvoltage fault response instead.
// RL16: Overcurrent: endless retries, counted retries, delayed shutdown, continue, or shutdown.
// RL17: Default overcurrent response shuts down and re-enables once the fault clears.
// RL18: Die temperature above programmable limit is a thermal fault; default 125 C.
// RL19: Thermal fault offers the same five responses as overcurrent.
// RL20: Thermal retry waits the delay, restarts only 15 C below limit, else waits again.
// RL21: Default thermal response shuts down and re-enables once temperature is back.
// RL22: Every comparator and sensor fault input is synchronised before use.
module power_fault_supervisor #(
  parameter int unsigned CNT_W   = 16,
  parameter int unsigned RETRY_W = 4
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        in_low_cmp,
  input  wire logic        ov_cmp,
  input  wire logic        oc_cmp,
  input  wire logic        hot_cmp,
  input  wire logic        cool_cmp,
  input  wire logic        win_low_cmp,
  input  wire logic        win_high_cmp,
  input  wire logic        pb_above_tgt_cmp,
  input  wire logic        pb_above_ov_cmp,
  input  wire logic        ext_clk_sel,
  input  wire logic        strap_low_pin,
  input  wire logic        strap_high_pin,
  output logic      [10:0] input_low_lockout,
  output logic      [7:0]  win_high_pct,
  output logic      [7:0]  win_low_pct,
  output logic      [7:0]  ov_pct,
  output logic      [7:0]  temp_limit,
  output logic      [7:0]  temp_restart,
  output logic             high_side_en,
  output logic             low_side_en,
  output logic             prebias_sample,
  output logic             ramp_from_prebias,
  output logic             duty_hold_prebias,
  output logic             ramp_down,
  output logic             output_in_range_flag,
  output logic             fault_latched
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  localparam int unsigned NSYNC = 12;

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;

  assign async_in = {strap_high_pin, strap_low_pin, ext_clk_sel, pb_above_ov_cmp,
                     pb_above_tgt_cmp, win_high_cmp, win_low_cmp, cool_cmp,
                     hot_cmp, oc_cmp, ov_cmp, in_low_cmp};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
        end
        else
        begin
          s1_r[gi] <= async_in[gi]; // see RL22
          s2_r[gi] <= s1_r[gi];
        end
      end
    end
  endgenerate

  wire uvl_s     = s2_r[0];
  wire ov_s      = s2_r[1];
  wire oc_s      = s2_r[2];
  wire hot_s     = s2_r[3];
  wire cool_s    = s2_r[4];
  wire wlow_s    = s2_r[5];
  wire whigh_s   = s2_r[6];
  wire pb_tgt_s  = s2_r[7];
  wire pb_ov_s   = s2_r[8];
  wire ext_clk_s = s2_r[9];
  wire strap_l_s = s2_r[10];
  wire strap_h_s = s2_r[11];

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] thr_r;
  logic [31:0] resp_r;
  logic [31:0] seq_r;
  logic [31:0] pgcfg_r;
  logic [31:0] window_r;
  logic [31:0] temp_r;
  logic [31:0] fdly_r;
  logic [31:0] prdata_r;
  logic [31:0] status;
  logic [31:0] rd_mux;

  wire hit_ctrl   = paddr == power_fault_pkg::OFS_CTRL;
  wire hit_thr    = paddr == power_fault_pkg::OFS_THR;
  wire hit_resp   = paddr == power_fault_pkg::OFS_RESP;
  wire hit_seq    = paddr == power_fault_pkg::OFS_SEQ;
  wire hit_pgcfg  = paddr == power_fault_pkg::OFS_PGCFG;
  wire hit_window = paddr == power_fault_pkg::OFS_WINDOW;
  wire hit_temp   = paddr == power_fault_pkg::OFS_TEMP;
  wire hit_fdly   = paddr == power_fault_pkg::OFS_FDLY;
  wire hit_status = paddr == power_fault_pkg::OFS_STATUS;
  wire hit_any    = hit_ctrl | hit_thr | hit_resp | hit_seq | hit_pgcfg | hit_window
                  | hit_temp | hit_fdly | hit_status;
  wire setup      = psel & ~penable;
  wire wr_en      = psel & penable & pwrite & hit_any;
  wire restart    = wr_en & hit_ctrl & pwdata[power_fault_pkg::CTRL_RESTART_BIT]; // see RL4

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_r;

  assign rd_mux = hit_ctrl   ? ctrl_r   :
                  hit_thr    ? thr_r    :
                  hit_resp   ? resp_r   :
                  hit_seq    ? seq_r    :
                  hit_pgcfg  ? pgcfg_r  :
                  hit_window ? window_r :
                  hit_temp   ? temp_r   :
                  hit_fdly   ? fdly_r   :
                  hit_status ? status   : 32'h0000_0000;

  // Read data is captured in the setup cycle so that it comes from a flop
  // while the access phase still completes without wait states.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctrl_r   <= power_fault_pkg::CTRL_RST;
      thr_r    <= power_fault_pkg::THR_RST;
      resp_r   <= power_fault_pkg::RESP_RST; // see RL17
      seq_r    <= power_fault_pkg::SEQ_RST;
      pgcfg_r  <= power_fault_pkg::PGCFG_RST;
      window_r <= power_fault_pkg::WINDOW_RST;
      temp_r   <= power_fault_pkg::TEMP_RST;
      fdly_r   <= power_fault_pkg::FDLY_RST;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      if (setup && !pwrite)
        prdata_r <= rd_mux;
      if (wr_en && hit_ctrl)
        ctrl_r <= pwdata & 32'h0000_0005;
      if (wr_en && hit_thr)
        thr_r <= {21'h00_0000, pwdata[10:0]}; // see RL2
      if (wr_en && hit_resp)
        resp_r <= pwdata & 32'h000F_7777;
      if (wr_en && hit_seq)
        seq_r <= pwdata;
      if (wr_en && hit_pgcfg)
        pgcfg_r <= pwdata & 32'h0001_FFFF; // see RL7
      if (wr_en && hit_window)
        window_r <= pwdata & 32'h00FF_FFFF; // see RL5
      if (wr_en && hit_temp)
        temp_r <= {24'h00_0000, pwdata[7:0]}; // see RL18
      if (wr_en && hit_fdly)
        fdly_r <= pwdata;
    end
  end

  // --------------------------------------------------------------------------
  // Lockout threshold
  // --------------------------------------------------------------------------
  logic [1:0]  settle_r;
  logic [10:0] strap_thr_r;
  logic [10:0] thr_lim;
  logic [10:0] lockout_r;

  wire strap_done = settle_r == 2'(power_fault_pkg::STRAP_SETTLE);
  wire thr_ovr    = ctrl_r[power_fault_pkg::CTRL_THR_OVR_BIT];

  assign thr_lim = (thr_r[10:0] < power_fault_pkg::THR_MIN) ? power_fault_pkg::THR_MIN :
                   (thr_r[10:0] > power_fault_pkg::THR_MAX) ? power_fault_pkg::THR_MAX :
                   thr_r[10:0]; // see RL2

  // The strap is caught once, after the synchronisers have filled.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      settle_r    <= 2'h0;
      strap_thr_r <= power_fault_pkg::THR_STRAP_OPEN;
      lockout_r   <= power_fault_pkg::THR_STRAP_OPEN;
    end
    else
    begin
      if (!strap_done)
        settle_r <= settle_r + 2'h1;
      if (settle_r == 2'(power_fault_pkg::STRAP_SETTLE - 1))
        strap_thr_r <= strap_l_s ? power_fault_pkg::THR_STRAP_LOW :
                       strap_h_s ? power_fault_pkg::THR_STRAP_HIGH :
                       power_fault_pkg::THR_STRAP_OPEN; // see RL1
      lockout_r <= thr_ovr ? thr_lim : strap_thr_r;
    end
  end

  // --------------------------------------------------------------------------
  // Microsecond tick and timers
  // --------------------------------------------------------------------------
  logic [6:0]       tick_r;
  logic [CNT_W-1:0] tmr_r;
  logic [CNT_W-1:0] tmr_tgt;
  logic [CNT_W-1:0] fcnt_r;
  logic [CNT_W-1:0] pgcnt_r;
  logic [CNT_W-1:0] pg_tgt;

  power_fault_pkg::seq_state_t state_r;
  power_fault_pkg::seq_state_t state_nxt;

  wire us_tick  = tick_r == 7'(power_fault_pkg::TICK_CYC - 1);
  wire tmr_done = tmr_r >= tmr_tgt;
  wire st_chg   = state_nxt != state_r;

  assign tmr_tgt = (state_r == power_fault_pkg::ST_DELAY)      ? seq_r[CNT_W-1:0]        :
                   (state_r == power_fault_pkg::ST_RAMP)       ? seq_r[16 +: CNT_W]      :
                   (state_r == power_fault_pkg::ST_RETRY_WAIT) ? fdly_r[16 +: CNT_W]     :
                   {CNT_W{1'b0}};
  assign pg_tgt  = pgcfg_r[power_fault_pkg::PG_INDEP_BIT] ? pgcfg_r[CNT_W-1:0]
                                                          : seq_r[16 +: CNT_W]; // see RL6

  // --------------------------------------------------------------------------
  // Per-source response selection
  // --------------------------------------------------------------------------
  logic [power_fault_pkg::NSRC-1:0] flt;
  logic [power_fault_pkg::NSRC-1:0] clr;
  logic [2:0]                       mode [power_fault_pkg::NSRC];
  logic [power_fault_pkg::NSRC-1:0] trip;
  logic [power_fault_pkg::NSRC-1:0] dly_req;

  assign flt = {uvl_s, hot_s, oc_s, ov_s};          // see RL18
  assign clr = {~uvl_s, cool_s, ~oc_s, ~ov_s};      // see RL20

  generate
    for (gi = 0; gi < power_fault_pkg::NSRC; gi++)
    begin : g_src
      wire [2:0] raw = resp_r[gi*power_fault_pkg::RESP_MODE_W +: 3];
      wire       ok  = (gi == power_fault_pkg::SRC_OV)  ?
                         (raw == power_fault_pkg::RESP_IMM ||
                          (raw == power_fault_pkg::RESP_LOWSIDE && !ext_clk_s)) : // see RL11
                       (gi == power_fault_pkg::SRC_UVL) ?
                         (raw <= power_fault_pkg::RESP_IMM) :                     // see RL3
                         (raw <= power_fault_pkg::RESP_RETRY_N);                  // see RL16, RL19
      assign mode[gi]    = ok ? raw : power_fault_pkg::RESP_IMM; // see RL9
      assign dly_req[gi] = flt[gi] && mode[gi] == power_fault_pkg::RESP_DLY_SHUT;
      assign trip[gi]    = flt[gi] && mode[gi] != power_fault_pkg::RESP_DLY_SHUT
                                   && mode[gi] != power_fault_pkg::RESP_CONT;
    end
  endgenerate

  wire fdly_done = |dly_req && fcnt_r >= fdly_r[CNT_W-1:0];
  wire in_power  = state_r == power_fault_pkg::ST_RAMP || state_r == power_fault_pkg::ST_RUN;
  wire pg_cond   = ~wlow_s & ~whigh_s & ~|flt;                                // see RL5

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tick_r  <= 7'h00;
      tmr_r   <= {CNT_W{1'b0}};
      fcnt_r  <= {CNT_W{1'b0}};
      pgcnt_r <= {CNT_W{1'b0}};
    end
    else
    begin
      tick_r  <= us_tick ? 7'h00 : tick_r + 7'h01;
      tmr_r   <= (st_chg || tmr_done) ? {CNT_W{1'b0}} : tmr_r + CNT_W'(us_tick);
      fcnt_r  <= (in_power && |dly_req) ? fcnt_r + CNT_W'(us_tick) : {CNT_W{1'b0}};
      pgcnt_r <= (in_power && pg_cond) ?
                 (pgcnt_r >= pg_tgt ? pgcnt_r : pgcnt_r + CNT_W'(us_tick)) :
                 {CNT_W{1'b0}}; // see RL6
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  logic [1:0]         src_r;
  logic [1:0]         src_nxt;
  logic [RETRY_W-1:0] retry_r;
  logic [RETRY_W-1:0] retry_nxt;
  logic               pb_hi_r;
  logic               pb_hi_nxt;
  logic               pg_r;
  logic               trip_any;
  logic [1:0]         trip_src;
  logic [2:0]         trip_mode;

  wire [RETRY_W-1:0] retry_lim = resp_r[power_fault_pkg::RESP_RETRY_LSB +: RETRY_W];
  wire               enable    = ctrl_r[power_fault_pkg::CTRL_ENABLE_BIT];

  // Lowest index wins: overvoltage is served ahead of the other sources.
  always_comb
  begin
    trip_any = 1'b0;
    trip_src = 2'h0;
    for (int i = power_fault_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (trip[i])
      begin
        trip_any = 1'b1;
        trip_src = 2'(i);
      end
    end
    trip_mode = mode[trip_src];
  end

  wire counted = trip_mode == power_fault_pkg::RESP_RETRY_N
              || (trip_mode != power_fault_pkg::RESP_RETRY_INF && retry_lim != '0);
  wire ov_start = pb_ov_s;

  always_comb
  begin
    state_nxt = state_r;
    src_nxt   = src_r;
    retry_nxt = retry_r;
    pb_hi_nxt = pb_hi_r;
    unique case (state_r)
      power_fault_pkg::ST_OFF:
        if (enable && !uvl_s)
          state_nxt = power_fault_pkg::ST_DELAY;
      power_fault_pkg::ST_DELAY:
        if (tmr_done)
        begin
          if (ov_start)
          begin
            src_nxt   = 2'(power_fault_pkg::SRC_OV); // see RL15
            state_nxt = (mode[power_fault_pkg::SRC_OV] == power_fault_pkg::RESP_LOWSIDE) ?
                        power_fault_pkg::ST_LOWSIDE : power_fault_pkg::ST_WAIT_CLEAR;
          end
          else
          begin
            pb_hi_nxt = pb_tgt_s; // see RL13
            state_nxt = power_fault_pkg::ST_RAMP;
          end
        end
      power_fault_pkg::ST_RAMP, power_fault_pkg::ST_RUN:
        if (trip_any)
        begin
          src_nxt = trip_src;
          if (counted && retry_r >= retry_lim)
            state_nxt = power_fault_pkg::ST_LATCHED; // see RL3
          else
          begin
            retry_nxt = retry_r + RETRY_W'(counted);
            state_nxt = (trip_mode == power_fault_pkg::RESP_LOWSIDE)   ? power_fault_pkg::ST_LOWSIDE :
                        (trip_mode == power_fault_pkg::RESP_IMM)       ? power_fault_pkg::ST_WAIT_CLEAR :
                        power_fault_pkg::ST_RETRY_WAIT; // see RL16
          end
        end
        else if (fdly_done)
          state_nxt = power_fault_pkg::ST_LATCHED; // see RL4
        else if (state_r == power_fault_pkg::ST_RAMP && tmr_done)
          state_nxt = power_fault_pkg::ST_RUN; // see RL14
      power_fault_pkg::ST_WAIT_CLEAR, power_fault_pkg::ST_LOWSIDE:
        if (clr[src_r])
          state_nxt = power_fault_pkg::ST_OFF; // see RL10, RL21
      power_fault_pkg::ST_RETRY_WAIT:
        if (tmr_done && clr[src_r])
          state_nxt = power_fault_pkg::ST_OFF; // see RL20
      power_fault_pkg::ST_LATCHED:
        if (restart)
        begin
          state_nxt = power_fault_pkg::ST_OFF;
          retry_nxt = '0;
        end
    endcase
    if (!enable && state_r != power_fault_pkg::ST_LATCHED)
      state_nxt = power_fault_pkg::ST_OFF;
    if (pg_r)
      retry_nxt = '0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r <= power_fault_pkg::ST_OFF;
      src_r   <= 2'h0;
      retry_r <= '0;
      pb_hi_r <= 1'b0;
      pg_r    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      src_r   <= src_nxt;
      retry_r <= retry_nxt;
      pb_hi_r <= pb_hi_nxt;
      pg_r    <= state_nxt == power_fault_pkg::ST_RUN && pg_cond && pgcnt_r >= pg_tgt; // see RL8
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  wire is_ramp = state_r == power_fault_pkg::ST_RAMP;
  wire is_run  = state_r == power_fault_pkg::ST_RUN;

  assign status = {1'b0, lockout_r, retry_r, 2'h0, src_r, 1'b0, 3'(state_r),
                   2'h0, fault_latched, pg_r, flt};

  assign input_low_lockout    = lockout_r;
  assign win_high_pct         = window_r[7:0];
  assign win_low_pct          = window_r[15:8];
  assign ov_pct               = window_r[23:16];
  assign temp_limit           = temp_r[7:0];
  assign temp_restart         = temp_r[7:0] - power_fault_pkg::TEMP_HYST; // see RL20
  assign high_side_en         = is_ramp | is_run;
  assign low_side_en          = is_ramp | is_run | (state_r == power_fault_pkg::ST_LOWSIDE);
  assign prebias_sample       = state_r == power_fault_pkg::ST_DELAY && tmr_done; // see RL12
  assign ramp_from_prebias    = is_ramp & ~pb_hi_r; // see RL13
  assign duty_hold_prebias    = is_ramp & pb_hi_r;  // see RL14
  assign ramp_down            = is_run & pb_hi_r;
  assign output_in_range_flag = pg_r;
  assign fault_latched        = state_r == power_fault_pkg::ST_LATCHED;

endmodule : power_fault_supervisor
